//--- bldc_chk.sv
/* bldc_chk: port assertions for the brushless commutation block.
   assumes: bound to bldc_commutation_startup; one clock, async reset. */
`timescale 1ns/100ps
module bldc_chk (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // comparators
   input wire overcurrent_in,
   // bridge
   input wire [2:0] high_switch,
   input wire [2:0] low_switch,
   input wire [1:0] bemf_mux_sel
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   high_one_leg_a: assert property ($onehot0(high_switch))
      else $error("more than one high-side switch on");
   no_shoot_a: assert property ((high_switch & low_switch) == 3'h0)
      else $error("both switches of one leg on");
   low_hold_a: assert property ($changed(low_switch) |=> $stable(low_switch) [*2])
      else $error("low-side switch not held for the step");
   align_leg_a: assert property (low_switch == 3'h6 |-> (high_switch & 3'h6) == 3'h0)
      else $error("alignment drives a wrong high-side switch");
   mux_float_a: assert property (($onehot(low_switch) && $stable(low_switch)) [*3]
      |-> low_switch[bemf_mux_sel] == 1'b0)
      else $error("comparator mux not on an undriven winding");
   oc_off_a: assert property (overcurrent_in [*6] |-> high_switch == 3'h0 && low_switch == 3'h0)
      else $error("bridge still driven under overcurrent");
   stop_off_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1]
      |-> ##[1:3] high_switch == 3'h0 && low_switch == 3'h0)
      else $error("bridge still driven after stop");
   reset_off_a: assert property (disable iff (1'b0) rst && $past(rst)
      |-> high_switch == 3'h0 && low_switch == 3'h0)
      else $error("bridge driven during reset");
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside the read cycle");
   rd_unmapped_a: assert property (reg_rd && reg_addr == 4'hf |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule

bind bldc_commutation_startup bldc_chk bldc_chk_inst (
   .sys_clk(sys_clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .overcurrent_in(overcurrent_in),
   .high_switch(high_switch),
   .low_switch(low_switch),
   .bemf_mux_sel(bemf_mux_sel)
);

//--- bldc_commutation_startup.v
/*
 * bldc_commutation_startup.v: commutation, start-up sequence, speed
 * measurement and overcurrent stop for a three-phase brushless motor.
 * assumes: hall, zero-cross and overcurrent comparator inputs are
 * asynchronous pins; software uses a one-cycle strobe register port.
 */
// Summary of operation
// (RULE1) start: align, ramp, then auto-commutate
// (RULE2) pwm only on active high-side switch
// (RULE3) low-side switch held on whole step
// (RULE4) back-emf sampled only in pwm off time
// (RULE5) off-time qualifying counter, count one, per edge
// (RULE6) one comparator, mux selects floating winding
// (RULE7) speed from time between same-winding crossings
// (RULE8) measured speed feeds pi controller
// (RULE9) pi output sets pwm duty
// (RULE10) selectable hall or sensorless mode
// (RULE11) hall event on both edges, each sensor
// (RULE12) each hall event updates switch pattern
// (RULE13) hall a edges capture speed timer
// (RULE14) sensorless align: a high, b c low on
// (RULE15) align current in equal timed duty steps
// (RULE16) ramp table shortening steps, constant current
// (RULE17) first ramp steps ignore position inputs
// (RULE18) then enable back-emf or hall detection
// (RULE19) all start parameters software programmable
// (RULE20) overcurrent stops the motor drive
// (RULE21) stopped or tripped: all six switches off
// (RULE22) boosted duty for preset time, then pi
`timescale 1ns/100ps
`include "bldc_ctrl_regs.vh"

module bldc_commutation_startup #(
   parameter TICK_CYCLES = `TICK_CYCLES
)
(
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // sensors and comparators
   input wire [2:0] hall_in,
   input wire zero_cross_in,
   input wire overcurrent_in,
   // bridge gate controls, index 0..2 = phase a..c
   output reg [2:0] high_switch,
   output reg [2:0] low_switch,
   output reg [1:0] bemf_mux_sel
);

   localparam ST_IDLE = 3'h0;
   localparam ST_ALIGN = 3'h1;
   localparam ST_RAMP = 3'h2;
   localparam ST_RUN = 3'h3;
   localparam ST_TRIP = 3'h4;

   // configuration registers
   reg sensorless_r, closed_loop_r, dir_r;
   reg [15:0] pwm_period_r, align_len_r, align_duty0_r, align_dinc_r;
   reg [7:0] align_steps_r, ramp_steps_r, ramp_forced_r;
   reg [15:0] ramp_duty_r, boost_duty_r, boost_len_r, speed_set_r;
   reg [7:0] kp_r, ki_r;
   reg [15:0] ramp_tab_r [0:3];

   // state
   reg [2:0] state_r;
   reg trip_r;
   reg [2:0] step_r;
   reg [7:0] step_cnt_r;
   reg [15:0] tmr_r;
   reg [15:0] tick_r;
   reg tick_pulse_r;
   reg [15:0] duty_r;
   reg [15:0] pwm_cnt_r;
   reg pwm_on_r;
   reg [15:0] boost_cnt_r;
   reg sync_r;
   reg [15:0] speed_cnt_r, speed_meas_r;
   reg [15:0] pi_out_r;
   reg [23:0] integ_r;
   reg hs_off_s1_r, hs_off_s2_r;
   reg zc_event_r;

   // synchronisers
   reg [2:0] hall_s1_r, hall_s2_r, hall_s3_r;
   reg zc_s1_r, zc_s2_r, zc_s3_r;
   reg oc_s1_r, oc_s2_r;

   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         hall_s1_r <= 3'h0;
         hall_s2_r <= 3'h0;
         hall_s3_r <= 3'h0;
         zc_s1_r <= 1'b0;
         zc_s2_r <= 1'b0;
         zc_s3_r <= 1'b0;
         oc_s1_r <= 1'b0;
         oc_s2_r <= 1'b0;
      end
      else
      begin
         hall_s1_r <= hall_in;
         hall_s2_r <= hall_s1_r;
         hall_s3_r <= hall_s2_r;
         zc_s1_r <= zero_cross_in;
         zc_s2_r <= zc_s1_r;
         zc_s3_r <= zc_s2_r;
         oc_s1_r <= overcurrent_in;
         oc_s2_r <= oc_s1_r;
      end
   end

   wire [2:0] hall_edge = hall_s2_r ^ hall_s3_r; // RULE11
   wire hall_event = |hall_edge;
   wire zc_rise = zc_s2_r & ~zc_s3_r;
   wire sw_start = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_START_BIT];
   wire sw_stop = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_STOP_BIT];
   wire trip_clr = reg_wr && reg_addr == `REG_CTRL && reg_wdata[`CTRL_TRIP_CLR];
   wire tmr_done = tmr_r == 16'h0000;

   // hall code 1..6 to commutation step 0..5; illegal codes hold the step
   reg [2:0] hall_step;
   always @*
   begin
      case (hall_s2_r)
         3'h5: hall_step = 3'h0;
         3'h1: hall_step = 3'h1;
         3'h3: hall_step = 3'h2;
         3'h2: hall_step = 3'h3;
         3'h6: hall_step = 3'h4;
         3'h4: hall_step = 3'h5;
         default: hall_step = step_r;
      endcase
   end

   wire [2:0] step_fwd = (step_r == 3'h5) ? 3'h0 : step_r + 3'h1;
   wire [2:0] step_rev = (step_r == 3'h0) ? 3'h5 : step_r - 3'h1;
   wire [2:0] step_next = dir_r ? step_rev : step_fwd;

   // position event: hall edge or off-time qualified crossing
   wire pos_event = sensorless_r ? zc_event_r : hall_event; // RULE10

   // software registers
   integer i;
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         sensorless_r <= 1'b0;
         closed_loop_r <= 1'b0;
         dir_r <= 1'b0;
         pwm_period_r <= `PWM_PERIOD_RST;
         align_steps_r <= `ALIGN_STEPS_RST;
         align_len_r <= `ALIGN_LEN_RST;
         align_duty0_r <= `ALIGN_DUTY0_RST;
         align_dinc_r <= `ALIGN_DINC_RST;
         ramp_steps_r <= `RAMP_STEPS_RST;
         ramp_forced_r <= `RAMP_FORCED_RST;
         ramp_duty_r <= `RAMP_DUTY_RST;
         boost_duty_r <= `BOOST_DUTY_RST;
         boost_len_r <= `BOOST_LEN_RST;
         kp_r <= `PI_KP_RST;
         ki_r <= `PI_KI_RST;
         speed_set_r <= `SPEED_SET_RST;
         for (i = 0; i < 4; i = i + 1)
            ramp_tab_r[i] <= `RAMP_TAB_RST;
      end
      else if (reg_wr)
      begin
         case (reg_addr) // RULE19
            `REG_CTRL:
            begin
               sensorless_r <= reg_wdata[`CTRL_SENSORLESS];
               closed_loop_r <= reg_wdata[`CTRL_CLOSED_LOOP];
               dir_r <= reg_wdata[`CTRL_DIR_BIT];
            end
            `REG_ALIGN_CFG:
            begin
               align_steps_r <= reg_wdata[7:0];
               align_len_r <= {8'h00, reg_wdata[15:8]};
            end
            `REG_ALIGN_DUTY:
            begin
               align_duty0_r <= {8'h00, reg_wdata[7:0]};
               align_dinc_r <= {8'h00, reg_wdata[15:8]};
            end
            `REG_RAMP_CFG:
            begin
               ramp_steps_r <= reg_wdata[7:0];
               ramp_forced_r <= reg_wdata[15:8];
            end
            `REG_RAMP_DUTY: ramp_duty_r <= reg_wdata;
            `REG_BOOST_CFG: boost_duty_r <= reg_wdata;
            `REG_PI_GAIN:
            begin
               kp_r <= reg_wdata[7:0];
               ki_r <= reg_wdata[15:8];
            end
            `REG_SPEED_SET: speed_set_r <= reg_wdata;
            `REG_PWM_PERIOD: pwm_period_r <= reg_wdata;
            `REG_SPEED_MEAS: boost_len_r <= reg_wdata;
            `REG_RAMP_TAB0: ramp_tab_r[0] <= reg_wdata;
            `REG_RAMP_TAB1: ramp_tab_r[1] <= reg_wdata;
            `REG_RAMP_TAB2: ramp_tab_r[2] <= reg_wdata;
            `REG_RAMP_TAB3: ramp_tab_r[3] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // interval timer tick
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tick_r <= 16'h0000;
         tick_pulse_r <= 1'b0;
      end
      else
      begin
         tick_pulse_r <= tick_r == TICK_CYCLES[15:0] - 16'h0001;
         tick_r <= (tick_r == TICK_CYCLES[15:0] - 16'h0001) ? 16'h0000 : tick_r + 16'h0001;
      end
   end

   // pwm carrier
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pwm_cnt_r <= 16'h0000;
         pwm_on_r <= 1'b0;
      end
      else
      begin
         pwm_cnt_r <= (pwm_cnt_r >= pwm_period_r - 16'h0001) ? 16'h0000 : pwm_cnt_r + 16'h0001;
         pwm_on_r <= pwm_cnt_r < duty_r;
      end
   end

   // off-time qualifier: the off flag is delayed as deep as the pin synchroniser,
   // so an edge is judged by the pwm phase in which the pin moved
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         hs_off_s1_r <= 1'b0;
         hs_off_s2_r <= 1'b0;
         zc_event_r <= 1'b0;
      end
      else
      begin
         hs_off_s1_r <= high_switch == 3'h0; // RULE4
         hs_off_s2_r <= hs_off_s1_r;
         // terminal count one: every qualified edge is an event
         zc_event_r <= hs_off_s2_r && zc_rise && sensorless_r; // RULE5
      end
   end

   // speed timer: capture on hall a edges or winding b crossings in step 1
   wire speed_cap = sensorless_r ? (zc_event_r && step_r[2:0] == 3'h1) // RULE7
                                 : hall_edge[0]; // RULE13
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         speed_cnt_r <= 16'h0000;
         speed_meas_r <= 16'h0000;
      end
      else if (speed_cap && sync_r)
      begin
         speed_meas_r <= speed_cnt_r;
         speed_cnt_r <= 16'h0000;
      end
      else if (speed_cnt_r != 16'hffff)
         speed_cnt_r <= speed_cnt_r + 16'h0001;
   end

   // pi loop on period error; shorter period means faster
   wire signed [16:0] err = {1'b0, speed_meas_r} - {1'b0, speed_set_r}; // RULE8
   wire signed [24:0] pi_sum = $signed({integ_r[23], integ_r}) + (err * $signed({1'b0, kp_r}));
   wire signed [24:0] integ_add = err * $signed({1'b0, ki_r});
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         integ_r <= 24'h000000;
         pi_out_r <= 16'h0000;
      end
      else if (state_r != ST_RUN)
      begin
         integ_r <= {8'h00, boost_duty_r};
         pi_out_r <= boost_duty_r;
      end
      else if (speed_cap)
      begin
         integ_r <= integ_r + integ_add[23:0];
         pi_out_r <= pi_sum[24] ? 16'h0000 : (|pi_sum[23:16] ? 16'hffff : pi_sum[15:0]);
      end
   end

   // start sequencer
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         trip_r <= 1'b0;
         step_r <= 3'h0;
         step_cnt_r <= 8'h00;
         tmr_r <= 16'h0000;
         duty_r <= 16'h0000;
         boost_cnt_r <= 16'h0000;
         sync_r <= 1'b0;
      end
      else if (oc_s2_r)
      begin
         state_r <= ST_TRIP; // RULE20
         trip_r <= 1'b1;
         duty_r <= 16'h0000;
         sync_r <= 1'b0;
      end
      else if (sw_stop)
      begin
         state_r <= ST_IDLE;
         duty_r <= 16'h0000;
         sync_r <= 1'b0;
      end
      else
      begin
         if (tick_pulse_r && !tmr_done)
            tmr_r <= tmr_r - 16'h0001;
         case (state_r)
            ST_IDLE:
               if (sw_start) // RULE1
               begin
                  state_r <= ST_ALIGN;
                  step_cnt_r <= 8'h00;
                  tmr_r <= align_len_r;
                  duty_r <= align_duty0_r;
                  step_r <= 3'h0;
               end
            ST_ALIGN:
               if (tick_pulse_r && tmr_done)
               begin
                  if (step_cnt_r + 8'h01 >= align_steps_r)
                  begin
                     state_r <= ST_RAMP;
                     step_cnt_r <= 8'h00;
                     tmr_r <= ramp_tab_r[0];
                     duty_r <= ramp_duty_r; // RULE16
                     step_r <= 3'h1;
                  end
                  else
                  begin
                     step_cnt_r <= step_cnt_r + 8'h01;
                     tmr_r <= align_len_r; // RULE15
                     duty_r <= duty_r + align_dinc_r;
                  end
               end
            ST_RAMP:
               if (step_cnt_r >= ramp_forced_r && pos_event) // RULE18
               begin
                  state_r <= ST_RUN;
                  sync_r <= 1'b1;
                  boost_cnt_r <= boost_len_r;
                  duty_r <= boost_duty_r;
                  step_r <= sensorless_r ? step_next : hall_step;
               end
               else if (tick_pulse_r && tmr_done) // RULE17
               begin
                  step_r <= step_next;
                  step_cnt_r <= step_cnt_r + 8'h01;
                  tmr_r <= ramp_tab_r[(step_cnt_r + 8'h01) > 8'h03 ? 2'h3 : step_cnt_r[1:0] + 2'h1];
                  if (step_cnt_r + 8'h01 >= ramp_steps_r && step_cnt_r >= ramp_forced_r)
                     state_r <= ST_IDLE;
               end
            ST_RUN:
            begin
               if (sensorless_r && zc_event_r)
                  step_r <= step_next;
               else if (!sensorless_r && hall_event)
                  step_r <= hall_step; // RULE12
               if (boost_cnt_r != 16'h0000)
               begin
                  if (tick_pulse_r)
                     boost_cnt_r <= boost_cnt_r - 16'h0001; // RULE22
               end
               else if (closed_loop_r)
                  duty_r <= pi_out_r; // RULE9
            end
            ST_TRIP:
               if (trip_clr)
               begin
                  state_r <= ST_IDLE;
                  trip_r <= 1'b0;
               end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // bridge pattern per step: high leg, low leg, floating leg
   reg [1:0] hi_leg, lo_leg, fl_leg;
   always @*
   begin
      case (step_r)
         3'h0: begin hi_leg = 2'd0; lo_leg = 2'd1; fl_leg = 2'd2; end
         3'h1: begin hi_leg = 2'd0; lo_leg = 2'd2; fl_leg = 2'd1; end
         3'h2: begin hi_leg = 2'd1; lo_leg = 2'd2; fl_leg = 2'd0; end
         3'h3: begin hi_leg = 2'd1; lo_leg = 2'd0; fl_leg = 2'd2; end
         3'h4: begin hi_leg = 2'd2; lo_leg = 2'd0; fl_leg = 2'd1; end
         3'h5: begin hi_leg = 2'd2; lo_leg = 2'd1; fl_leg = 2'd0; end
         default: begin hi_leg = 2'd0; lo_leg = 2'd1; fl_leg = 2'd2; end
      endcase
   end

   wire running = state_r == ST_RAMP || state_r == ST_RUN;
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         high_switch <= 3'h0;
         low_switch <= 3'h0;
         bemf_mux_sel <= 2'd0;
      end
      else if (oc_s2_r || trip_r || state_r == ST_IDLE)
      begin
         high_switch <= 3'h0; // RULE21
         low_switch <= 3'h0;
      end
      else if (state_r == ST_ALIGN)
      begin
         high_switch <= {2'b00, pwm_on_r}; // RULE14
         low_switch <= 3'b110;
      end
      else if (running)
      begin
         high_switch <= pwm_on_r ? (3'b001 << hi_leg) : 3'h0; // RULE2
         low_switch <= 3'b001 << lo_leg; // RULE3
         bemf_mux_sel <= fl_leg; // RULE6
      end
   end

   // read port
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `REG_CTRL: reg_rdata <= {10'h000, 1'b0, dir_r, closed_loop_r, sensorless_r, 2'b00};
            `REG_STATUS: reg_rdata <= {8'h00, step_r, sync_r, trip_r, state_r};
            `REG_ALIGN_CFG: reg_rdata <= {align_len_r[7:0], align_steps_r};
            `REG_ALIGN_DUTY: reg_rdata <= {align_dinc_r[7:0], align_duty0_r[7:0]};
            `REG_RAMP_CFG: reg_rdata <= {ramp_forced_r, ramp_steps_r};
            `REG_RAMP_DUTY: reg_rdata <= ramp_duty_r;
            `REG_BOOST_CFG: reg_rdata <= boost_duty_r;
            `REG_PI_GAIN: reg_rdata <= {ki_r, kp_r};
            `REG_SPEED_SET: reg_rdata <= speed_set_r;
            `REG_SPEED_MEAS: reg_rdata <= speed_meas_r;
            `REG_PWM_PERIOD: reg_rdata <= pwm_period_r;
            `REG_RAMP_TAB0: reg_rdata <= ramp_tab_r[0];
            `REG_RAMP_TAB1: reg_rdata <= ramp_tab_r[1];
            `REG_RAMP_TAB2: reg_rdata <= ramp_tab_r[2];
            `REG_RAMP_TAB3: reg_rdata <= ramp_tab_r[3];
            default: reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

endmodule

//--- bldc_ctrl_regs.vh
/*
 * bldc_ctrl_regs.vh: register offsets, field positions, reset values and
 * timing counts for the brushless motor commutation block.
 * assumes: included by bldc_commutation_startup.v and by the bench; definitions only.
 */
`ifndef BLDC_CTRL_REGS_VH
`define BLDC_CTRL_REGS_VH

// register offsets (word index on the plain register port)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_ALIGN_CFG   4'h2
`define REG_ALIGN_DUTY  4'h3
`define REG_RAMP_CFG    4'h4
`define REG_RAMP_DUTY   4'h5
`define REG_BOOST_CFG   4'h6
`define REG_PI_GAIN     4'h7
`define REG_SPEED_SET   4'h8
`define REG_SPEED_MEAS  4'h9
`define REG_PWM_PERIOD  4'ha
`define REG_RAMP_TAB0   4'hb
`define REG_RAMP_TAB1   4'hc
`define REG_RAMP_TAB2   4'hd
`define REG_RAMP_TAB3   4'he

// control fields
`define CTRL_START_BIT    0
`define CTRL_STOP_BIT     1
`define CTRL_SENSORLESS   2
`define CTRL_CLOSED_LOOP  3
`define CTRL_DIR_BIT      4
`define CTRL_TRIP_CLR     5

// status fields
`define STAT_STATE_LSB    0
`define STAT_TRIP_BIT     3
`define STAT_SYNC_BIT     4
`define STAT_STEP_LSB     5

// reset values
`define PWM_PERIOD_RST    16'h03e8
`define ALIGN_STEPS_RST   8'h08
`define ALIGN_LEN_RST     16'h0064
`define ALIGN_DUTY0_RST   16'h0032
`define ALIGN_DINC_RST    16'h0019
`define RAMP_STEPS_RST    8'h04
`define RAMP_FORCED_RST   8'h02
`define RAMP_DUTY_RST     16'h0190
`define BOOST_DUTY_RST    16'h02bc
`define BOOST_LEN_RST     16'h07d0
`define PI_KP_RST         8'h04
`define PI_KI_RST         8'h01
`define SPEED_SET_RST     16'h1000
`define RAMP_TAB_RST      16'h0800

// timing: interval timer tick of 100 us at a 100 ns clock
`define TICK_US           100
`define CLK_NS            100
`define TICK_CYCLES       ((`TICK_US * 1000) / `CLK_NS)

`endif

//--- inverter_motor_model.sv
/* inverter_motor_model: behavioural bridge and motor with hall, back-emf
   and overcurrent comparators.
   assumes: gate controls active high; fault request comes from the bench. */
`timescale 1ns/100ps
module inverter_motor_model #(
   parameter STEP_CYCLES = 40
)
(
   // clock
   input wire sys_clk,
   // gate controls
   input wire [2:0] high_switch,
   input wire [2:0] low_switch,
   // fault request
   input wire oc_fault,
   // sensors and comparators
   output reg [2:0] hall_in,
   output reg zero_cross_in,
   output wire overcurrent_in
);
   integer cnt_r;
   reg [2:0] pos_r;

   assign overcurrent_in = oc_fault;

   initial
   begin
      cnt_r = 0;
      pos_r = 3'h0;
      hall_in = 3'h1;
      zero_cross_in = 1'b0;
   end

   // rotor stops at once while no low side conducts
   always @(posedge sys_clk)
   begin
      if (low_switch != 3'h0)
      begin
         cnt_r <= (cnt_r == STEP_CYCLES - 1) ? 0 : cnt_r + 1;
         if (cnt_r == STEP_CYCLES - 1)
            pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
      end
      case (pos_r)
         3'h0: hall_in <= 3'h1;
         3'h1: hall_in <= 3'h3;
         3'h2: hall_in <= 3'h2;
         3'h3: hall_in <= 3'h6;
         3'h4: hall_in <= 3'h4;
         default: hall_in <= 3'h5;
      endcase
   end

   // crossing half way through a step; neutral is near ground only with the high side off
   always @(negedge sys_clk)
      zero_cross_in <= cnt_r >= STEP_CYCLES / 2 && (zero_cross_in || high_switch == 3'h0);
endmodule

//--- tb_top.sv
/* tb_top: self-checking bench for the commutation block.
   assumes: tick shortened to 10 clocks; motor model steps every 40 clocks. */
`timescale 1ns/100ps
`include "bldc_ctrl_regs.vh"
module tb_top;
   reg sys_clk;
   reg rst;
   reg [3:0] reg_addr;
   reg [15:0] reg_wdata;
   reg reg_wr;
   reg reg_rd;
   wire [15:0] reg_rdata;
   wire [2:0] hall_in;
   wire zero_cross_in;
   wire overcurrent_in;
   wire [2:0] high_switch;
   wire [2:0] low_switch;
   wire [1:0] bemf_mux_sel;
   reg oc_fault;
   reg [15:0] rv;
   integer num_errors;
   integer num_checks;

   bldc_commutation_startup #(.TICK_CYCLES(10)) bldc_commutation_startup_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .hall_in(hall_in),
      .zero_cross_in(zero_cross_in),
      .overcurrent_in(overcurrent_in),
      .high_switch(high_switch),
      .low_switch(low_switch),
      .bemf_mux_sel(bemf_mux_sel)
   );

   inverter_motor_model #(.STEP_CYCLES(40)) inverter_motor_model_inst (
      .sys_clk(sys_clk),
      .high_switch(high_switch),
      .low_switch(low_switch),
      .oc_fault(oc_fault),
      .hall_in(hall_in),
      .zero_cross_in(zero_cross_in),
      .overcurrent_in(overcurrent_in)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task test_done;
   begin
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask

   task check(input [15:0] seen, input [15:0] exp);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask

   // a spare cycle after each strobe keeps drivers single-assigned
   task wr(input [3:0] a, input [15:0] d);
   begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   end
   endtask

   task rd(input [3:0] a);
   begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge sys_clk);
   end
   endtask

   task wait_state(input [2:0] s);
      integer n;
   begin
      n = 0;
      rd(`REG_STATUS);
      while (rv[2:0] !== s && n < 300)
      begin
         rd(`REG_STATUS);
         n = n + 1;
      end
      check(rv[2:0], s);
   end
   endtask

   task count_hi(output [15:0] c);
      integer k;
   begin
      c = 16'h0000;
      for (k = 0; k < 16; k = k + 1)
      begin
         @(negedge sys_clk);
         c = c + {15'h0, high_switch[0]};
      end
      @(posedge sys_clk);
   end
   endtask

   // legs in use over one pwm period: pwm high legs and low legs
   task step_pat(output [5:0] p);
      integer k;
   begin
      p = {3'h0, low_switch};
      for (k = 0; k < 8; k = k + 1)
      begin
         @(negedge sys_clk);
         p[5:3] = p[5:3] | high_switch;
      end
      @(posedge sys_clk);
   end
   endtask

   task test_regs;
   begin
      rd(`REG_STATUS);
      check(rv, 16'h0000);
      rd(`REG_RAMP_CFG);
      check(rv, {`RAMP_FORCED_RST, `RAMP_STEPS_RST});
      rd(`REG_PI_GAIN);
      check(rv, {`PI_KI_RST, `PI_KP_RST});
      rd(`REG_SPEED_SET);
      check(rv, `SPEED_SET_RST);
      rd(`REG_RAMP_TAB3);
      check(rv, `RAMP_TAB_RST);
      wr(4'hf, 16'hffff);
      rd(4'hf);
      check(rv, 16'h0000);
      wr(`REG_RAMP_TAB1, 16'h0a5c);
      rd(`REG_RAMP_TAB1);
      check(rv, 16'h0a5c);
   end
   endtask

   task cfg;
   begin
      wr(`REG_PWM_PERIOD, 16'h0008);
      wr(`REG_ALIGN_CFG, 16'h0402);
      wr(`REG_ALIGN_DUTY, 16'h0302);
      wr(`REG_RAMP_CFG, 16'h0204);
      wr(`REG_RAMP_DUTY, 16'h0004);
      wr(`REG_BOOST_CFG, 16'h0004);
      wr(`REG_SPEED_MEAS, 16'h0002);
      wr(`REG_RAMP_TAB0, 16'h0004);
      wr(`REG_RAMP_TAB1, 16'h0003);
      wr(`REG_RAMP_TAB2, 16'h0003);
      wr(`REG_RAMP_TAB3, 16'h0003);
   end
   endtask

   task test_sensorless;
      reg [15:0] c1;
      reg [15:0] c2;
   begin
      cfg;
      wr(`REG_CTRL, 16'h0005);
      wait_state(3'h1);
      check(low_switch, 3'h6);
      count_hi(c1);
      repeat (22) @(posedge sys_clk);
      count_hi(c2);
      check(c2 > c1, 1'b1);
      wait_state(3'h2);
      wait_state(3'h3);
      check(rv[4], 1'b1);
      // first capture after sync spans the idle time; wait for a second one
      repeat (600) @(posedge sys_clk);
      rd(`REG_SPEED_MEAS);
      check(rv >= 16'd40 && rv <= 16'd300, 1'b1);
      wr(`REG_CTRL, 16'h0006);
      @(posedge sys_clk);
      check({high_switch, low_switch}, 6'h00);
      wait_state(3'h0);
   end
   endtask

   task test_overcurrent;
   begin
      wr(`REG_CTRL, 16'h0005);
      wait_state(3'h1);
      oc_fault <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check({high_switch, low_switch}, 6'h00);
      wait_state(3'h4);
      check(rv[3], 1'b1);
      wr(`REG_CTRL, 16'h0005);
      rd(`REG_STATUS);
      check(rv[2:0], 3'h4);
      oc_fault <= 1'b0;
      // clear only once the synchronised fault has gone
      repeat (3) @(posedge sys_clk);
      wr(`REG_CTRL, 16'h0024);
      wait_state(3'h0);
   end
   endtask

   task test_hall;
      reg [5:0] prev;
      reg [5:0] p;
      reg [2:0] h0;
      integer i;
      integer n;
   begin
      wr(`REG_CTRL, 16'h0001);
      wait_state(3'h3);
      step_pat(prev);
      for (i = 0; i < 6; i = i + 1)
      begin
         h0 = hall_in;
         n = 0;
         while (hall_in === h0 && n < 100)
         begin
            @(posedge sys_clk);
            n = n + 1;
         end
         repeat (4) @(posedge sys_clk);
         step_pat(p);
         check(p != prev, 1'b1);
         prev = p;
      end
      rd(`REG_SPEED_MEAS);
      check(rv >= 16'd40 && rv <= 16'd300, 1'b1);
      wr(`REG_CTRL, 16'h0002);
   end
   endtask

   initial
   begin
      num_errors = 0;
      num_checks = 0;
      rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      oc_fault = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      test_regs;
      test_sensorless;
      test_overcurrent;
      test_hall;
      test_done;
   end

   // whole run needs well under 8000 clocks
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors = num_errors + 1;
      test_done;
   end
endmodule
